// file: uefc_pkg.sv
// Constants and carrier types shared by the USB endpoint FIFO controller.
package uefc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NFIFO = 4;
  localparam int AW = 11;
  localparam int CW = 12;
  localparam int NRAM = 7;
  localparam int LARGE_IDX = 3;
  localparam logic [CW-1:0] CAP_SMALL = 12'h040;
  localparam logic [CW-1:0] CAP_LARGE = 12'h800;
  localparam logic [CW-1:0] SETUP_LEN = 12'h008;
  localparam logic [NFIFO-1:0] TX_ISO_OK = 4'h8;
  localparam logic [NFIFO-1:0] RX_ISO_OK = 4'h8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] OFS_STAT = 12'h000;
  localparam logic [11:0] OFS_MASK = 12'h004;
  localparam logic [11:0] OFS_FLAGS = 12'h008;
  localparam logic [6:0] OFS_CAP_PAGE = 7'h01;
  localparam int NEV = 10;
  localparam int EV_RX = 0;
  localparam int EV_TX = 4;
  localparam int EV_SETUP = 8;
  localparam int EV_ISO = 9;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic cmt;
    logic wrw;
    logic rd;
    logic rel;
    logic rrw;
  } uefc_ctl_t;

  typedef struct packed {
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;
    logic full;
    logic empty;
    logic set_rdy;
    logic rd_end;
    logic cmt_ok;
    logic [CW-1:0] wr_cnt;
  } uefc_stat_t;

endpackage : uefc_pkg

// file: uefc_fifo_ptr.sv
// Pointer, fill count and data-set tracking for one endpoint FIFO.
`timescale 1ns/10ps
module uefc_fifo_ptr #(
  parameter int LEVELS = 1
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Programmed capacity in bytes.
  input wire logic [uefc_pkg::CW-1:0] cap,
  // Requests in, state out.
  input wire uefc_pkg::uefc_ctl_t ctl,
  output uefc_pkg::uefc_stat_t st
);
  import uefc_pkg::*;

  logic [AW-1:0] wr_ptr_q, wr_start_q, rd_ptr_q, rd_start_q;
  logic [CW-1:0] used_q, wr_cnt_q, rd_cnt_q;
  logic [CW-1:0] len_q [2];
  logic [1:0] sets_q;
  logic hd_q;

  function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] a,
                                             input logic [CW-1:0] n,
                                             input logic [CW-1:0] c);
    logic [CW:0] s;
    s = {2'b00, a} + {1'b0, n};
    wrap_add = (s >= {1'b0, c}) ? AW'(s - {1'b0, c}) : AW'(s);
  endfunction : wrap_add

  wire logic [CW-1:0] head_len = len_q[hd_q];
  wire logic sets_max = (sets_q == 2'(LEVELS));
  wire logic full = (used_q >= cap) || sets_max;
  wire logic set_rdy = (sets_q != 2'b00);
  // With no set held there is nothing to have finished, so the end flag stays low.
  wire logic rd_end = set_rdy && (rd_cnt_q == head_len);
  wire logic do_wrw = ctl.wrw;
  wire logic do_cmt = ctl.cmt && !do_wrw && !sets_max;
  wire logic do_wr = ctl.wr && !do_wrw && !ctl.cmt && !full;
  wire logic do_rrw = ctl.rrw;
  wire logic do_rel = ctl.rel && !do_rrw && set_rdy;
  wire logic do_rd = ctl.rd && !do_rrw && !ctl.rel && set_rdy && !rd_end;
  wire logic tail = hd_q ^ set_rdy;
  wire logic [CW-1:0] used_d = used_q + CW'(do_wr) - (do_wrw ? wr_cnt_q : '0)
                               - (do_rel ? head_len : '0);
  wire logic [1:0] sets_d = sets_q + 2'(do_cmt) - 2'(do_rel);

  assign st = '{wr_addr: wr_ptr_q, rd_addr: rd_ptr_q, full: full, // R7
                empty: (used_q == '0), set_rdy: set_rdy, rd_end: rd_end,
                cmt_ok: !do_wrw && !sets_max, wr_cnt: wr_cnt_q};

  // ****************************************************************
  // Write side
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      wr_start_q <= '0;
      wr_cnt_q <= '0;
      used_q <= '0;
      sets_q <= '0;
      len_q <= '{default: '0};
    end
    else
    begin
      used_q <= used_d;
      sets_q <= sets_d;
      if (do_wrw)
      begin
        wr_ptr_q <= wr_start_q; // R8
        wr_cnt_q <= '0;
      end
      else if (do_cmt)
      begin
        wr_start_q <= wr_ptr_q;
        wr_cnt_q <= '0;
        len_q[tail] <= wr_cnt_q; // R6
      end
      else if (do_wr)
      begin
        wr_ptr_q <= wrap_add(wr_ptr_q, CW'(1), cap);
        wr_cnt_q <= wr_cnt_q + CW'(1);
      end
    end
  end

  // ****************************************************************
  // Read side
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q <= '0;
      rd_start_q <= '0;
      rd_cnt_q <= '0;
      hd_q <= 1'b0;
    end
    else if (do_rrw)
    begin
      rd_ptr_q <= rd_start_q; // R10
      rd_cnt_q <= '0;
    end
    else if (do_rel)
    begin
      rd_start_q <= wrap_add(rd_start_q, head_len, cap);
      rd_ptr_q <= wrap_add(rd_start_q, head_len, cap);
      rd_cnt_q <= '0;
      hd_q <= (LEVELS > 1) ? ~hd_q : 1'b0; // R6
    end
    else if (do_rd)
    begin
      rd_ptr_q <= wrap_add(rd_ptr_q, CW'(1), cap);
      rd_cnt_q <= rd_cnt_q + CW'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_rewind_start: assert property (do_rrw |=> rd_ptr_q == $past(rd_start_q) && rd_cnt_q == '0) // R10
    else $error("Rewind did not return to start of data set.");
  a_full_last: assert property (do_wr && !do_rel && used_q == cap - CW'(1) |=> full) // R7
    else $error("FIFO not full after last byte.");
  a_sets_bound: assert property (sets_q <= 2'(LEVELS)) // R6
    else $error("More data sets held than levels.");

endmodule : uefc_fifo_ptr

// file: uefc_top.sv
// Endpoint FIFO controller: pointer units, RAM strobes, app port and APB.
`timescale 1ns/10ps

// Overview of operation
// R1 - Eight endpoint FIFOs are kept, four transmitting toward the host and four receiving.
// R2 - Transmit FIFOs serve endpoints 0,5,6,7 and receive 0,1,2,3, capacity 64 or 2K on 7 and 3.
// R3 - Transmit FIFOs of endpoints 5 and 6 refuse isochronous traffic.
// R4 - Transmit endpoint 7 takes every transfer type with capacity up to 2K bytes.
// R5 - Receive endpoint 3 takes isochronous data, endpoints 1 and 2 take bulk only.
// R6 - Endpoints 3 and 7 hold up to two data sets of independent sizes.
// R7 - Each FIFO keeps full and empty flags matching its fill state.
// R8 - Each FIFO can resend or re-receive its current data set.
// R9 - All FIFO work is done here, with a parallel byte port for the application.
// R10 - A resend or re-receive returns to the set's first byte and leaves other sets alone.
// R11 - A four-bit packet-available output is high while a receive FIFO holds a committed data set.
// R12 - The application's low-active strobe qualifies write data and read data.
// R13 - One low-active write strobe per transmit RAM, seven, with shared address and data.
// R14 - A setup-available flag rises once eight setup bytes have been received.
module uefc_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // APB register port.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Application byte port.
  input wire logic app_strobe_n,
  input wire logic app_dir_wr,
  input wire logic app_commit,
  input wire logic [1:0] app_ep,
  input wire logic [7:0] app_write_byte,
  output logic [7:0] app_read_byte,
  output logic [uefc_pkg::NFIFO-1:0] pkt_rdy,
  output logic setup_rdy,
  // Serial engine, transmit direction.
  input wire logic sie_tx_rd,
  input wire logic sie_tx_ack,
  input wire logic sie_tx_retry,
  input wire logic sie_tx_iso,
  input wire logic [1:0] sie_tx_ep,
  output logic [7:0] sie_tx_data,
  output logic [uefc_pkg::NFIFO-1:0] sie_tx_rdy,
  output logic [uefc_pkg::NFIFO-1:0] sie_tx_end,
  // Serial engine, receive direction.
  input wire logic sie_rx_wr,
  input wire logic sie_rx_good,
  input wire logic sie_rx_bad,
  input wire logic sie_rx_iso,
  input wire logic sie_rx_setup,
  input wire logic [1:0] sie_rx_ep,
  input wire logic [7:0] sie_rx_data,
  output logic [uefc_pkg::NFIFO-1:0] sie_rx_full,
  // Transmit RAMs.
  input wire logic [7:0] trx_out_data,
  output logic [7:0] trx_in_data,
  output logic [2:0] trx_sel,
  output logic [uefc_pkg::AW-1:0] trx_wr_ptr,
  output logic [uefc_pkg::AW-1:0] trx_rd_ptr,
  output logic [uefc_pkg::NRAM-1:0] trx_wrb,
  // Receive RAMs.
  input wire logic [7:0] rcv_out_data,
  output logic [7:0] rcv_in_data,
  output logic [2:0] rcv_sel,
  output logic [uefc_pkg::AW-1:0] rcv_wr_ptr,
  output logic [uefc_pkg::AW-1:0] rcv_rd_ptr,
  output logic [uefc_pkg::NRAM-1:0] rcv_wrb
);
  import uefc_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic ep_hit(input logic [1:0] ep, input int i);
    ep_hit = (ep == 2'(i));
  endfunction : ep_hit

  function automatic logic [CW-1:0] cap_max(input logic [2:0] k);
    cap_max = (k[1:0] == 2'(LARGE_IDX)) ? CAP_LARGE : CAP_SMALL;
  endfunction : cap_max

  uefc_ctl_t tx_ctl [NFIFO];
  uefc_ctl_t rx_ctl [NFIFO];
  uefc_stat_t tx_st [NFIFO];
  uefc_stat_t rx_st [NFIFO];
  logic [CW-1:0] cap_q [2*NFIFO];
  logic [NFIFO-1:0] tx_wr_ok, rx_wr_ok, rx_cmt_ev, tx_rel_ev, rx_rdy, tx_rdy;
  logic [NFIFO-1:0] tx_end, rx_full, tx_full, rx_empty, tx_empty;
  logic [NEV-1:0] status_q, mask_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, strobe_prev_q, setup_rdy_q;
  logic [7:0] app_read_byte_q, sie_tx_data_q, trx_in_data_q, rcv_in_data_q;
  logic [NFIFO-1:0] pkt_rdy_q, sie_tx_rdy_q, sie_tx_end_q, sie_rx_full_q;
  logic [2:0] trx_sel_q, rcv_sel_q;
  logic [AW-1:0] trx_wr_ptr_q, trx_rd_ptr_q, rcv_wr_ptr_q, rcv_rd_ptr_q;
  logic [NRAM-1:0] trx_wrb_q, rcv_wrb_q;

  // ****************************************************************
  // Application port decode
  // ****************************************************************
  // One access per low period of the strobe; a long low phase is not repeated.
  wire logic app_fall = !app_strobe_n && strobe_prev_q; // R12
  wire logic app_wr = app_fall && app_dir_wr && !app_commit;
  wire logic app_wcmt = app_fall && app_dir_wr && app_commit;
  wire logic app_rd = app_fall && !app_dir_wr && !app_commit;
  wire logic app_rel = app_fall && !app_dir_wr && app_commit;
  wire logic rx_byte = sie_rx_wr && !sie_rx_good && !sie_rx_bad;
  wire logic tx_iso_bad = sie_tx_iso && !TX_ISO_OK[sie_tx_ep];
  wire logic rx_iso_bad = sie_rx_iso && !RX_ISO_OK[sie_rx_ep];
  wire logic iso_ev = (tx_iso_bad && (sie_tx_rd || sie_tx_ack)) // R3
                      || (rx_iso_bad && (sie_rx_wr || sie_rx_good)); // R5
  wire logic setup_ev = rx_cmt_ev[0] && sie_rx_setup
                        && (rx_st[0].wr_cnt == SETUP_LEN);
  wire logic [NEV-1:0] ev = {iso_ev, setup_ev, tx_rel_ev, rx_cmt_ev};

  // ****************************************************************
  // Endpoint FIFOs
  // ****************************************************************
  for (genvar i = 0; i < NFIFO; i++)
  begin : g_fifo
    localparam int LV = (i == LARGE_IDX) ? 2 : 1;
    wire logic tx_ok = !sie_tx_iso || TX_ISO_OK[i];
    wire logic rx_ok = !sie_rx_iso || RX_ISO_OK[i];
    wire logic ta = ep_hit(app_ep, i);
    wire logic ts = ep_hit(sie_tx_ep, i) && tx_ok;
    wire logic rs = ep_hit(sie_rx_ep, i) && rx_ok;

    assign tx_ctl[i] = '{wr: app_wr && ta, cmt: app_wcmt && ta, wrw: 1'b0, // R9
                         rd: sie_tx_rd && ts, rel: sie_tx_ack && ts,
                         rrw: sie_tx_retry && ts}; // R8
    assign rx_ctl[i] = '{wr: rx_byte && rs, cmt: sie_rx_good && rs,
                         wrw: sie_rx_bad && rs, rd: app_rd && ta, // R8
                         rel: app_rel && ta, rrw: 1'b0};
    assign tx_wr_ok[i] = tx_ctl[i].wr && !tx_st[i].full;
    assign rx_wr_ok[i] = rx_ctl[i].wr && !rx_st[i].full;
    assign rx_cmt_ev[i] = rx_ctl[i].cmt && rx_st[i].cmt_ok;
    assign tx_rel_ev[i] = tx_ctl[i].rel && tx_st[i].set_rdy;
    assign rx_rdy[i] = rx_st[i].set_rdy;
    assign tx_rdy[i] = tx_st[i].set_rdy;
    assign tx_end[i] = tx_st[i].rd_end;
    assign rx_full[i] = rx_st[i].full;
    assign tx_full[i] = tx_st[i].full;
    assign rx_empty[i] = rx_st[i].empty;
    assign tx_empty[i] = tx_st[i].empty;

    uefc_fifo_ptr #(.LEVELS(LV)) u_tx ( // R1 R6
      .clock(clock),
      .rst(rst),
      .cap(cap_q[i]),
      .ctl(tx_ctl[i]),
      .st(tx_st[i])
    );

    uefc_fifo_ptr #(.LEVELS(LV)) u_rx ( // R1 R6
      .clock(clock),
      .rst(rst),
      .cap(cap_q[NFIFO+i]),
      .ctl(rx_ctl[i]),
      .st(rx_st[i])
    );
  end

  // ****************************************************************
  // RAM ports
  // ****************************************************************
  // Addresses are registered together with the strobe, so the RAM sees
  // the byte's own slot before the pointer moved on.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      trx_wrb_q <= '1;
      trx_wr_ptr_q <= '0;
      trx_in_data_q <= '0;
      trx_rd_ptr_q <= '0;
      trx_sel_q <= '0;
    end
    else
    begin
      trx_wrb_q <= ~NRAM'(tx_wr_ok); // R13
      trx_wr_ptr_q <= tx_st[app_ep].wr_addr;
      trx_in_data_q <= app_write_byte;
      trx_rd_ptr_q <= tx_st[sie_tx_ep].rd_addr;
      trx_sel_q <= {1'b0, sie_tx_ep};
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rcv_wrb_q <= '1;
      rcv_wr_ptr_q <= '0;
      rcv_in_data_q <= '0;
      rcv_rd_ptr_q <= '0;
      rcv_sel_q <= '0;
    end
    else
    begin
      rcv_wrb_q <= ~NRAM'(rx_wr_ok);
      rcv_wr_ptr_q <= rx_st[sie_rx_ep].wr_addr;
      rcv_in_data_q <= sie_rx_data;
      rcv_rd_ptr_q <= rx_st[app_ep].rd_addr;
      rcv_sel_q <= {1'b0, app_ep};
    end
  end

  // ****************************************************************
  // Data and flag outputs
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      strobe_prev_q <= 1'b1;
      app_read_byte_q <= '0;
      sie_tx_data_q <= '0;
    end
    else
    begin
      strobe_prev_q <= app_strobe_n;
      if (app_rd)
        app_read_byte_q <= rcv_out_data; // R9
      if (sie_tx_rd)
        sie_tx_data_q <= trx_out_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pkt_rdy_q <= '0;
      sie_tx_rdy_q <= '0;
      sie_tx_end_q <= '0;
      sie_rx_full_q <= '0;
      setup_rdy_q <= 1'b0;
    end
    else
    begin
      pkt_rdy_q <= rx_rdy; // R11
      sie_tx_rdy_q <= tx_rdy;
      sie_tx_end_q <= tx_end;
      sie_rx_full_q <= rx_full; // R7
      setup_rdy_q <= setup_ev || (setup_rdy_q && !rx_ctl[0].rel); // R14
    end
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  // One wait state on every access gives the read mux a full cycle.
  wire logic apb_acc = psel && penable && !pready_q;
  wire logic apb_wr = psel && penable && pready_q && pwrite;
  wire logic cap_hit = (paddr[11:5] == OFS_CAP_PAGE) && (paddr[1:0] == 2'b00);
  wire logic [2:0] cap_idx = paddr[4:2];
  wire logic reg_hit = cap_hit || (paddr == OFS_STAT) || (paddr == OFS_MASK)
                       || (paddr == OFS_FLAGS);
  wire logic [CW-1:0] cap_wv = pwdata[CW-1:0];
  wire logic [CW-1:0] cap_d = (cap_wv == '0 || cap_wv > cap_max(cap_idx))
                              ? cap_max(cap_idx) : cap_wv; // R2 R4
  wire logic [NEV-1:0] w1c = (apb_wr && paddr == OFS_STAT) ? pwdata[NEV-1:0] : '0;
  wire logic [31:0] rd_mux = (paddr == OFS_STAT) ? 32'(status_q)
                           : (paddr == OFS_MASK) ? 32'(mask_q)
                           : (paddr == OFS_FLAGS) ? {16'h0000, rx_empty, tx_empty,
                                                     rx_full, tx_full} // R7
                           : cap_hit ? 32'(cap_q[cap_idx]) : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !reg_hit;
      prdata_q <= (apb_acc && !pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < 2 * NFIFO; k++)
        cap_q[k] <= cap_max(3'(k));
      mask_q <= '0;
    end
    else
    begin
      if (apb_wr && cap_hit)
        cap_q[cap_idx] <= cap_d;
      if (apb_wr && paddr == OFS_MASK)
        mask_q <= pwdata[NEV-1:0];
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~w1c) | ev;
      irq_q <= |(status_q & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign app_read_byte = app_read_byte_q;
  assign pkt_rdy = pkt_rdy_q;
  assign setup_rdy = setup_rdy_q;
  assign sie_tx_data = sie_tx_data_q;
  assign sie_tx_rdy = sie_tx_rdy_q;
  assign sie_tx_end = sie_tx_end_q;
  assign sie_rx_full = sie_rx_full_q;
  assign trx_in_data = trx_in_data_q;
  assign trx_sel = trx_sel_q;
  assign trx_wr_ptr = trx_wr_ptr_q;
  assign trx_rd_ptr = trx_rd_ptr_q;
  assign trx_wrb = trx_wrb_q;
  assign rcv_in_data = rcv_in_data_q;
  assign rcv_sel = rcv_sel_q;
  assign rcv_wr_ptr = rcv_wr_ptr_q;
  assign rcv_rd_ptr = rcv_rd_ptr_q;
  assign rcv_wrb = rcv_wrb_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_app_write;
    app_wr && !tx_st[app_ep].full;
  endsequence

  sequence s_rx_commit;
    rx_cmt_ev != '0;
  endsequence

  a_tx_strobe: assert property (s_app_write |=> trx_wrb_q[NRAM-1:NFIFO] == '1 // R13
      && $countones(~trx_wrb_q) == 1 && trx_in_data_q == $past(app_write_byte))
    else $error("Transmit RAM strobe or data wrong after app write.");
  a_pkt_rdy_rise: assert property (s_rx_commit |-> ##2 ((pkt_rdy_q & $past(rx_cmt_ev, 2)) // R11
      == $past(rx_cmt_ev, 2)))
    else $error("Packet available did not follow a committed set.");
  a_iso_refuse: assert property (sie_tx_rd && sie_tx_iso && sie_tx_ep == 2'b01 // R3
      |=> status_q[EV_ISO] && $stable(tx_st[1].rd_addr))
    else $error("Isochronous read of bulk-only transmit FIFO not refused.");
  a_iso_rx: assert property (rx_byte && sie_rx_iso && sie_rx_ep == 2'b10 // R5
      |=> status_q[EV_ISO] && rcv_wrb_q == '1)
    else $error("Isochronous byte to bulk-only receive FIFO not refused.");
  a_cap_limit: assert property (cap_q[LARGE_IDX] <= CAP_LARGE && cap_q[0] <= CAP_SMALL // R2 R4
      && cap_q[NFIFO] <= CAP_SMALL && cap_q[NFIFO+LARGE_IDX] <= CAP_LARGE)
    else $error("Programmed capacity out of range.");
  a_setup_flag: assert property (setup_ev |=> setup_rdy_q ##1 (setup_rdy_q // R14
      || $past(rx_ctl[0].rel)))
    else $error("Setup flag did not rise on eight setup bytes.");
  a_apb_wait: assert property (apb_acc |=> pready_q ##1 !pready_q)
    else $error("APB answer not exactly one wait state.");
  a_irq_level: assert property ((status_q & mask_q) != '0 |=> irq_q)
    else $error("Interrupt not raised for unmasked status.");

endmodule : uefc_top

// file: uefc_app_model.sv
// Application-side model driving the byte port of the endpoint FIFO controller.
`timescale 1ns/10ps
module uefc_app_model (
  // Clock.
  input wire logic clock,
  // Byte port toward the controller.
  output logic app_strobe_n,
  output logic app_dir_wr,
  output logic app_commit,
  output logic [1:0] app_ep,
  output logic [7:0] app_write_byte
);
  initial
  begin
    app_strobe_n = 1'b1;
    app_dir_wr = 1'b0;
    app_commit = 1'b0;
    app_ep = 2'h0;
    app_write_byte = 8'h00;
  end
  // The endpoint settles a cycle before the strobe falls, since the RAM address is registered.
  // Data is inverted outside the strobe so that nothing can lean on a stale byte.
  task automatic access(input logic w, input logic c, input logic [1:0] e, input logic [7:0] d);
    @(posedge clock);
    app_dir_wr <= w;
    app_commit <= c;
    app_ep <= e;
    @(posedge clock);
    app_strobe_n <= 1'b0;
    app_write_byte <= d;
    @(posedge clock);
    app_strobe_n <= 1'b1;
    app_write_byte <= ~d;
    #1;
  endtask : access
endmodule : uefc_app_model

// file: tb_top.sv
// Self-checking bench for the endpoint FIFO controller.
`timescale 1ns/10ps
module tb_top;
  import uefc_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, setup_rdy, perr;
  logic app_strobe_n, app_dir_wr, app_commit, sie_tx_rd, sie_tx_ack, sie_tx_retry, sie_tx_iso;
  logic sie_rx_wr, sie_rx_good, sie_rx_bad, sie_rx_iso, sie_rx_setup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] app_ep, sie_tx_ep, sie_rx_ep;
  logic [7:0] app_write_byte, app_read_byte, sie_tx_data, sie_rx_data;
  logic [7:0] trx_out_data, trx_in_data, rcv_out_data, rcv_in_data;
  logic [3:0] pkt_rdy, sie_tx_rdy, sie_tx_end, sie_rx_full;
  logic [2:0] trx_sel, rcv_sel;
  logic [10:0] trx_wr_ptr, trx_rd_ptr, rcv_wr_ptr, rcv_rd_ptr;
  logic [6:0] trx_wrb, rcv_wrb;
  logic [7:0] tram [7][2048];
  logic [7:0] rram [7][2048];
  int fail_count, total_checks;
  uefc_top dut (.*);
  uefc_app_model app (.*);
  // ************************************************************
  // Clock and behavioural RAMs
  // ************************************************************
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
    for (int i = 0; i < 7; i++)
    begin
      if (!trx_wrb[i]) tram[i][trx_wr_ptr] <= trx_in_data;
      if (!rcv_wrb[i]) rram[i][rcv_wr_ptr] <= rcv_in_data;
    end
  assign trx_out_data = tram[trx_sel][trx_rd_ptr];
  assign rcv_out_data = rram[rcv_sel][rcv_rd_ptr];
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  // Op is 0 tx read, 1 tx ack, 2 tx retry, 3 rx write, 4 rx good, 5 rx bad.
  task automatic sie(input int op, input logic [1:0] e, input logic [7:0] d);
    @(posedge clock);
    {sie_tx_rd, sie_tx_ack, sie_tx_retry, sie_rx_wr, sie_rx_good, sie_rx_bad} <= 6'h20 >> op;
    sie_tx_ep <= e;
    sie_rx_ep <= e;
    sie_rx_data <= d;
    @(posedge clock);
    {sie_tx_rd, sie_tx_ack, sie_tx_retry, sie_rx_wr, sie_rx_good, sie_rx_bad} <= 6'h00;
    sie_rx_data <= ~d;
    #1;
  endtask : sie
  task automatic settle;
    @(posedge clock);
    #1;
  endtask : settle
  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {sie_tx_rd, sie_tx_ack, sie_tx_retry, sie_tx_iso, sie_tx_ep} = 6'h0;
    {sie_rx_wr, sie_rx_good, sie_rx_bad, sie_rx_iso, sie_rx_setup, sie_rx_ep} = 7'h0;
    sie_rx_data = 8'h00;
    {fail_count, total_checks} = {32'h0, 32'h0};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    settle();
    chk({trx_wrb, rcv_wrb, pkt_rdy, setup_rdy, irq}, 20'hfffc0);
    rchk(OFS_MASK, 32'h0);
    for (int k = 0; k < 8; k++) rchk(12'h020 + 12'(4 * k), (k % 4 == 3) ? 32'h800 : 32'h040);
    apb(1'b0, 12'hffc, 32'h0);
    chk({perr, rd}, 33'h100000000);
    apb(1'b1, 12'h020, 32'h2);
    rchk(12'h020, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      app.access(1'b1, 1'b0, 2'h0, 8'ha0 + 8'(i));
      chk({trx_wrb, trx_in_data}, {(i < 2) ? 7'h7e : 7'h7f, 8'ha0 + 8'(i)});
    end
    rchk(OFS_FLAGS, 32'hfe01);
    app.access(1'b1, 1'b1, 2'h0, 8'h00);
    settle();
    chk(sie_tx_rdy, 4'h1);
    sie(0, 2'h0, 8'h00);
    chk(sie_tx_data, 8'ha0);
    sie(0, 2'h0, 8'h00);
    chk(sie_tx_data, 8'ha1);
    settle();
    chk(sie_tx_end, 4'h1);
    sie(2, 2'h0, 8'h00);
    sie(0, 2'h0, 8'h00);
    chk(sie_tx_data, 8'ha0);
    sie(1, 2'h0, 8'h00);
    settle();
    chk(sie_tx_rdy, 4'h0);
    sie_tx_iso <= 1'b1;
    sie(0, 2'h1, 8'h00);
    sie_tx_iso <= 1'b0;
    rchk(OFS_STAT, 32'h210);
    apb(1'b1, OFS_STAT, 32'h3ff);
    for (int i = 0; i < 3; i++) sie(3, 2'h0, 8'h11);
    sie(5, 2'h0, 8'h00);
    for (int i = 0; i < 8; i++) sie(3, 2'h0, 8'h40 + 8'(i));
    sie_rx_setup <= 1'b1;
    sie(4, 2'h0, 8'h00);
    sie_rx_setup <= 1'b0;
    settle();
    chk({pkt_rdy, setup_rdy, irq}, 6'h06);
    apb(1'b1, OFS_MASK, 32'h3ff);
    settle();
    chk(irq, 1'b1);
    rchk(OFS_STAT, 32'h101);
    apb(1'b1, OFS_STAT, 32'h3ff);
    settle();
    chk(irq, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      app.access(1'b0, 1'b0, 2'h0, 8'h00);
      chk(app_read_byte, 8'h40 + 8'(i));
    end
    app.access(1'b0, 1'b1, 2'h0, 8'h00);
    settle();
    chk({pkt_rdy, setup_rdy}, 5'h00);
    sie_rx_iso <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      sie(3, 2'h3, 8'h61 + 8'(i));
      if (i != 1) sie(4, 2'h3, 8'h00);
    end
    sie(3, 2'h2, 8'h55);
    sie_rx_iso <= 1'b0;
    rchk(OFS_FLAGS, 32'h7f80);
    chk(sie_rx_full, 4'h8);
    rchk(OFS_STAT, 32'h208);
    app.access(1'b0, 1'b0, 2'h3, 8'h00);
    chk(app_read_byte, 8'h61);
    app.access(1'b0, 1'b1, 2'h3, 8'h00);
    settle();
    chk(pkt_rdy, 4'h8);
    for (int i = 0; i < 2; i++)
    begin
      app.access(1'b0, 1'b0, 2'h3, 8'h00);
      chk(app_read_byte, 8'h62 + 8'(i));
    end
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim();
  end
endmodule : tb_top
